/* File: brot_consts.svh */
// constants and overview for the byte rotate datapath
// Overview of operation
// RULE1: rotate_left_mem shifts the addressed byte left one place, old bit 7 into bit 0, writes it back, flags untouched.
// RULE2: rotate_left_to_acc puts the same left rotation into the accumulator, memory byte unchanged, no flags.
// RULE3: rotate_left_carry_mem rotates byte and carry as a 9-bit ring, old bit 7 into carry, result written back.
// RULE4: both through-carry left rotates put the old carry into bit 0 and change only the carry flag.
// RULE5: rotate_left_carry_to_acc puts the 9-bit left rotation into the accumulator, sets carry from old bit 7, memory unchanged.
// RULE6: rotate_right_mem shifts the byte right one place, old bit 0 into bit 7, writes it back, no flags.
// RULE7: in-place rotates do read, compute and write back as one read-modify-write in one instruction.
`ifndef BROT_CONSTS_SVH
`define BROT_CONSTS_SVH
`define BROT_DATA_W 8
`define BROT_MSB 7
`define BROT_LSB 0
`define BROT_ACC_RESET 8'h00
`define BROT_CARRY_RESET 1'b0
`define BROT_ADDR_W 8
`endif

/* File: brot_datapath.sv */
// byte rotate datapath: sequences read, rotate and, for in-place ops, write back per instruction
`timescale 1ns/1ps
`include "brot_consts.svh"
module brot_datapath #(
    parameter int W = `BROT_DATA_W,
    parameter int AW = `BROT_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire brot_pkg::brot_req_t req_in,
    input wire logic req_valid_in,
    input wire logic [W-1:0] mem_rdata_in,
    input wire logic carry_in,
    input wire logic carry_load_in,
    output logic busy_out,
    output logic [AW-1:0] mem_raddr_out,
    output logic mem_re_out,
    output brot_pkg::brot_wr_t mem_wr_out,
    output logic [W-1:0] acc_out,
    output logic carry_out,
    output logic done_out
);
    import brot_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} brot_state_t;

    brot_state_t state_q;
    brot_op_t op_q;
    logic [AW-1:0] addr_q;
    logic [W-1:0] acc_q;
    logic carry_q;
    brot_wr_t wr_q;
    logic re_q;
    logic done_q;
    // busy gets its own flop so the core never sees a decode glitch
    logic busy_q;

    wire logic is_left;
    wire logic is_thru;
    wire logic to_mem;
    wire logic to_acc;
    wire logic [W-1:0] rot_data;
    wire logic rot_carry;
    wire logic start;
    wire logic exec;

    assign start = (state_q == ST_IDLE) && req_valid_in && (req_in.op != BROT_OP_NONE);
    assign exec = (state_q == ST_EXEC);
    assign is_left = (op_q != BROT_OP_RR_MEM);
    // RULE4 carry feeds bit 0 only on carry ops
    assign is_thru = (op_q == BROT_OP_RLC_MEM) || (op_q == BROT_OP_RLC_ACC);
    assign to_mem = (op_q == BROT_OP_RL_MEM) || (op_q == BROT_OP_RLC_MEM)
        || (op_q == BROT_OP_RR_MEM);
    assign to_acc = (op_q == BROT_OP_RL_ACC) || (op_q == BROT_OP_RLC_ACC);

    brot_rotator #(.W(W)) brot_rotator_inst (
        .data_in(mem_rdata_in),
        .carry_in(carry_q),
        .left_in(is_left),
        .thru_carry_in(is_thru),
        .data_out(rot_data),
        .carry_out(rot_carry)
    );

    // RULE7 one read per instruction, then one write for in-place ops
    // no queue: a request that arrives while busy is simply dropped
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
            op_q <= BROT_OP_NONE;
            addr_q <= '0;
            re_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        op_q <= req_in.op;
                        addr_q <= req_in.addr;
                        re_q <= 1'b1;
                        busy_q <= 1'b1;
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    re_q <= 1'b0;
                    state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    busy_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // RULE1 in-place results go back to memory
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            done_q <= 1'b0;
        end else begin
            wr_q.we <= exec && to_mem;
            wr_q.addr <= addr_q;
            wr_q.data <= rot_data;
            done_q <= exec;
        end
    end

    // RULE2 accumulator loads only on to-acc ops
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_q <= `BROT_ACC_RESET;
        end else if (exec && to_acc) begin
            acc_q <= rot_data;
        end
    end

    // RULE5 carry from old bit 7, core load otherwise
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            carry_q <= `BROT_CARRY_RESET;
        end else if (exec && is_thru) begin
            carry_q <= rot_carry;
        end else if (carry_load_in && state_q == ST_IDLE) begin
            carry_q <= carry_in;
        end
    end

    assign busy_out = busy_q;
    assign mem_raddr_out = addr_q;
    assign mem_re_out = re_q;
    assign mem_wr_out = wr_q;
    assign acc_out = acc_q;
    assign carry_out = carry_q;
    assign done_out = done_q;

    sequence exec_rl_mem_s;
        exec && op_q == BROT_OP_RL_MEM;
    endsequence

    sequence exec_rlc_s;
        exec && is_thru;
    endsequence

    // the three visible steps of one instruction
    sequence read_step_s;
        mem_re_out && busy_out;
    endsequence

    sequence exec_step_s;
        !mem_re_out && busy_out;
    endsequence

    sequence retire_step_s;
        !busy_out && done_out;
    endsequence

    rl_mem_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE1
        exec_rl_mem_s |=> mem_wr_out.we && mem_wr_out.data == {$past(mem_rdata_in[6:0]),
            $past(mem_rdata_in[7])} && carry_out == $past(carry_q))
        else $error("left rotate in place wrong");

    rl_acc_only_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE2
        exec && op_q == BROT_OP_RL_ACC |=> !mem_wr_out.we
            && acc_out == {$past(mem_rdata_in[6:0]), $past(mem_rdata_in[7])}
            && $stable(carry_out))
        else $error("left rotate to accumulator wrong");

    rlc_carry_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE3
        exec_rlc_s |=> carry_out == $past(mem_rdata_in[7]))
        else $error("carry not from old top bit");

    rlc_bit0_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE4
        exec && op_q == BROT_OP_RLC_MEM |=> mem_wr_out.data[0] == $past(carry_q)
            && mem_wr_out.data[7:1] == $past(mem_rdata_in[6:0]))
        else $error("through-carry bit 0 wrong");

    rlc_acc_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE5
        exec && op_q == BROT_OP_RLC_ACC |=> !mem_wr_out.we
            && acc_out == {$past(mem_rdata_in[6:0]), $past(carry_q)})
        else $error("through-carry to accumulator wrong");

    rr_mem_wrap_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE6
        exec && op_q == BROT_OP_RR_MEM |=> mem_wr_out.we
            && mem_wr_out.data == {$past(mem_rdata_in[0]), $past(mem_rdata_in[7:1])}
            && carry_out == $past(carry_q))
        else $error("right rotate in place wrong");

    rmw_sequence_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
        start |=> read_step_s ##1 exec_step_s ##1 retire_step_s)
        else $error("read-modify-write sequence broken");

    write_once_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
        mem_wr_out.we |-> done_out && !$past(mem_wr_out.we))
        else $error("memory written outside instruction end");

    plain_carry_kept_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE1
        exec && !is_thru |=> $stable(carry_out))
        else $error("plain rotate touched the carry");

    mem_acc_kept_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE6
        exec && to_mem |=> $stable(acc_out))
        else $error("in-place rotate touched the accumulator");

    // the accumulator may only move at the end of an instruction
    acc_at_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE2
        $changed(acc_out) |-> done_out)
        else $error("accumulator changed outside instruction end");

    // carry has two sources: a through-carry op or a core load while idle
    carry_source_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE4
        $changed(carry_out) |-> done_out || ($past(carry_load_in) && !$past(busy_out)))
        else $error("carry changed outside its two sources");

    read_addr_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
        start |=> mem_raddr_out == $past(req_in.addr))
        else $error("operand read from wrong address");

    busy_refuse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
        busy_out |=> $stable(op_q) && $stable(mem_raddr_out))
        else $error("request taken while busy");

    done_single_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE7
        done_out |=> !done_out)
        else $error("done pulse longer than one cycle");
endmodule

/* File: brot_datapath_test.sv */
// self-checking bench for the byte rotate datapath
`timescale 1ns/1ps
module brot_datapath_test;
import brot_pkg::*;
typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] acc;
    logic c;
} brot_exp_t;
logic sys_clk_in = 1'b0;
logic rst_n_in = 1'b0;
brot_req_t req_in = '0;
logic req_valid_in = 1'b0;
logic [7:0] mem_rdata_in = 8'h00;
logic carry_in = 1'b0;
logic carry_load_in = 1'b0;
logic busy_out, mem_re_out, carry_out, done_out, rd_hold = 1'b0;
logic [7:0] mem_raddr_out, acc_out, e_acc = 8'h00;
logic e_c = 1'b0;
brot_wr_t mem_wr_out;
logic [7:0] mem [256];
brot_exp_t notes [$];
int bad_count = 0;
int total_checks = 0;
int cycles = 0;

always #25 sys_clk_in = ~sys_clk_in;

brot_datapath brot_datapath_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .req_in(req_in), .req_valid_in(req_valid_in), .mem_rdata_in(mem_rdata_in),
    .carry_in(carry_in), .carry_load_in(carry_load_in), .busy_out(busy_out),
    .mem_raddr_out(mem_raddr_out), .mem_re_out(mem_re_out), .mem_wr_out(mem_wr_out),
    .acc_out(acc_out), .carry_out(carry_out), .done_out(done_out));

task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask

task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
        bad_count++;
        $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
endtask

// read data held two clock cycles, then scrambled so stale bytes never match
always @(negedge sys_clk_in) begin
    if (mem_re_out === 1'b1) begin
        mem_rdata_in <= mem[mem_raddr_out];
        rd_hold <= 1'b1;
    end else if (rd_hold) begin
        rd_hold <= 1'b0;
    end else begin
        mem_rdata_in <= ~mem_rdata_in;
    end
end

always @(posedge sys_clk_in) begin
    if (mem_wr_out.we === 1'b1) begin
        mem[mem_wr_out.addr] <= mem_wr_out.data;
    end
    cycles++;
    if (cycles == 3000) begin
        bad_count++;
        complete_run();
    end
end

always @(negedge sys_clk_in) begin
    brot_exp_t e;
    if (mem_re_out === 1'b1) begin
        if (notes.size() == 0) begin
            chk(8'h01, 8'h00);
        end else begin
            chk(mem_raddr_out, notes[0].addr);
            chk({7'h00, busy_out}, 8'h01);
        end
    end
    if (done_out === 1'b1) begin
        if (notes.size() == 0) begin
            chk(8'h01, 8'h00);
        end else begin
            e = notes.pop_front();
            chk({7'h00, mem_wr_out.we}, {7'h00, e.we});
            chk({7'h00, busy_out}, 8'h00);
            if (e.we) chk(mem_wr_out.addr, e.addr);
            if (e.we) chk(mem_wr_out.data, e.data);
            chk(acc_out, e.acc);
            chk({7'h00, carry_out}, {7'h00, e.c});
        end
    end
end

task automatic run_op(input brot_op_t op, input logic [7:0] a, input logic c);
    logic [7:0] m;
    logic [7:0] d;
    int n;
    carry_load_in = 1'b1;
    carry_in = c;
    e_c = c;
    @(negedge sys_clk_in);
    carry_load_in = 1'b0;
    m = mem[a];
    d = 8'h00;
    case (op)
        BROT_OP_RL_MEM: d = {m[6:0], m[7]};
        BROT_OP_RL_ACC: e_acc = {m[6:0], m[7]};
        BROT_OP_RLC_MEM: begin d = {m[6:0], e_c}; e_c = m[7]; end
        BROT_OP_RLC_ACC: begin e_acc = {m[6:0], e_c}; e_c = m[7]; end
        default: d = {m[0], m[7:1]};
    endcase
    notes.push_back({(op == BROT_OP_RL_MEM || op == BROT_OP_RLC_MEM || op == BROT_OP_RR_MEM),
        a, d, e_acc, e_c});
    req_in = {op, a};
    req_valid_in = 1'b1;
    @(negedge sys_clk_in);
    // busy now: this request and carry load must be ignored
    req_in = {BROT_OP_RR_MEM, ~a};
    carry_load_in = 1'b1;
    carry_in = ~e_c;
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    carry_load_in = 1'b0;
    n = 0;
    while (busy_out !== 1'b0 && n < 20) begin
        @(negedge sys_clk_in);
        n++;
    end
    chk(8'(n), 8'h01);
endtask

initial begin
    void'($urandom(32'h2a6e71cb));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    mem[0] = 8'h80;
    mem[255] = 8'h01;
    repeat (5) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < 10; i++) run_op(brot_op_t'(1 + i % 5), (i % 2) ? 8'hff : 8'h00, i[1]);
    req_in = {BROT_OP_NONE, 8'h00};
    req_valid_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    req_valid_in = 1'b0;
    $display("directed test done");
    // mid-run reset: outputs clear, the next instruction must still run
    rst_n_in = 1'b0;
    e_acc = 8'h00;
    @(negedge sys_clk_in);
    chk(acc_out, 8'h00);
    chk({busy_out, mem_re_out, done_out, carry_out, mem_wr_out.we, 3'h0}, 8'h00);
    chk(mem_wr_out.data, 8'h00);
    chk(mem_raddr_out, 8'h00);
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    $display("reset test done");
    for (int i = 0; i < 40; i++) run_op(brot_op_t'(1 + $urandom % 5), 8'($urandom), 1'($urandom));
    $display("random test done");
    repeat (4) @(negedge sys_clk_in);
    chk(8'(notes.size()), 8'h00);
    complete_run();
end
endmodule

/* File: brot_pkg.sv */
// types for the byte rotate datapath
package brot_pkg;
    typedef enum logic [2:0] {
        BROT_OP_NONE,
        BROT_OP_RL_MEM,
        BROT_OP_RL_ACC,
        BROT_OP_RLC_MEM,
        BROT_OP_RLC_ACC,
        BROT_OP_RR_MEM
    } brot_op_t;

    typedef struct packed {
        brot_op_t op;
        logic [7:0] addr;
    } brot_req_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } brot_wr_t;
endpackage

/* File: brot_rotator.sv */
// combinational one-place byte rotator
`timescale 1ns/1ps
`include "brot_consts.svh"
module brot_rotator #(
    parameter int W = `BROT_DATA_W
) (
    input wire logic [W-1:0] data_in,
    input wire logic carry_in,
    input wire logic left_in,
    input wire logic thru_carry_in,
    output logic [W-1:0] data_out,
    output logic carry_out
);
    wire logic fill_left;
    wire logic fill_right;
    // RULE1 top bit wraps round
    assign fill_left = thru_carry_in ? carry_in : data_in[W-1];
    // RULE6 bottom bit wraps round
    assign fill_right = thru_carry_in ? carry_in : data_in[0];
    assign data_out = left_in ? {data_in[W-2:0], fill_left} : {fill_right, data_in[W-1:1]};
    // RULE3 carry takes the bit shifted out
    assign carry_out = left_in ? data_in[W-1] : data_in[0];
endmodule
